//--- sfe_pkg.sv
// Purpose: shared constants and types for the serial flash erase and id block
// Assumes: 20 MHz system clock, serial link sampled as ordinary inputs
// Notes:   opcodes, bit counts, region sizes and status bit positions
package sfe_pkg;

    // opcodes
    localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
    localparam logic [7:0] OP_READ_STATUS     = 8'h05;
    localparam logic [7:0] OP_SECTOR_ERASE    = 8'h20;
    localparam logic [7:0] OP_HALF_BLOCK      = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE     = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A    = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B    = 8'hC7;
    localparam logic [7:0] OP_MAKER_DEVICE_ID = 8'h90;
    localparam logic [7:0] OP_IDENT_READ      = 8'h9F;
    localparam logic [7:0] OP_UNIQUE_ID       = 8'h4B;

    // input bit counts
    localparam logic [5:0] CNT_OPCODE_END = 6'h08;
    localparam logic [5:0] CNT_ADDR_END   = 6'h20;
    localparam logic [5:0] CNT_DUMMY_END  = 6'h28;
    localparam logic [5:0] CNT_MAX        = 6'h3F;

    // erase region sizes in bytes
    localparam logic [23:0] SECTOR_BYTES     = 24'h001000;
    localparam logic [23:0] HALF_BLOCK_BYTES = 24'h008000;
    localparam logic [23:0] BLOCK_BYTES      = 24'h010000;

    // status byte bit positions
    localparam int ST_WIP_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_BP_LSB  = 2;

    // clock rate
    localparam int unsigned CLK_HZ     = 20000000;
    localparam int unsigned CLK_PER_US = CLK_HZ / 1000000;

    typedef enum logic [1:0] {
        ERASE_SECTOR     = 2'h0,
        ERASE_HALF_BLOCK = 2'h1,
        ERASE_BLOCK      = 2'h2,
        ERASE_CHIP       = 2'h3
    } sfe_erase_type;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0001,
        ST_SHIFT_IN  = 4'b0010,
        ST_SHIFT_OUT = 4'b0100,
        ST_IGNORE    = 4'b1000
    } sfe_state_type;

endpackage : sfe_pkg

//--- sfe_pin_sync.sv
// Purpose: two-flop synchronisers with edge detect for serial pins
// Assumes: pins are asynchronous to clk_sys
// Notes:   edges taken from second and third stages only
module sfe_pin_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic         ce,
    // pins
    input  wire logic [W-1:0] pin_in,
    // synchronised view
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_next;
    logic [W-1:0] prev_next;

    // pins idle high after reset
    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
        prev_next = sync_reg;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_reg <= '1;
            sync_reg <= '1;
            prev_reg <= '1;
        end else if (ce) begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_edge
            assign rise[i] = sync_reg[i] & ~prev_reg[i];
            assign fall[i] = ~sync_reg[i] & prev_reg[i];
        end
    endgenerate

    assign level = sync_reg;

endmodule : sfe_pin_sync

//--- sfe_erase_timer.sv
// Purpose: self-timed erase cycle counter
// Assumes: start arrives only while idle
// Notes:   busy rises the edge after start and lasts the loaded count
module sfe_erase_timer (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        ce,
    // control
    input  wire logic        start,
    input  wire logic [31:0] cycles,
    // status
    output logic             busy,
    output logic             done
);

    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic        busy_reg;
    logic        busy_next;
    logic        done_reg;
    logic        done_next;

    always_comb begin
        count_next = count_reg;
        busy_next  = busy_reg;
        done_next  = 1'b0;
        if (start && !busy_reg) begin
            count_next = (cycles == 32'h0) ? 32'h1 : cycles;
            busy_next  = 1'b1;
        end else if (busy_reg) begin
            count_next = count_reg - 32'h1;
            if (count_reg == 32'h1) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_reg <= 32'h0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else if (ce) begin
            count_reg <= count_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;

endmodule : sfe_erase_timer

//--- sfe_cmd.sv
// Purpose: serial flash erase and identification command handling
// Assumes: link pins sampled by clk_sys, link clock well below clk_sys/4
// Notes:   status read and write enable decoded so erase can be gated

// What this block does
// - sector erase 20H plus three address bytes
// - erase only with write enable latch set
// - address erase needs select rise at bit 32
// - erase cycle sets write in progress
// - write enable latch cleared before cycle ends
// - status reads served during erase cycle
// - protected sector or block not erased
// - half block erase 52H, own duration
// - block erase D8H, own duration
// - chip erase 60H/C7H, select rise at 8
// - chip erase only for three protect settings
// - 90H, address, then maker and device
// - 9FH shifts out three identification bytes
// - identification read ignored while cycle runs
// - select rise ends output, back to standby
// - 4BH, address, dummy, 128-bit unique number
// - input bits sampled on serial clock rise
module sfe_cmd #(
    parameter logic [23:0]  MEM_BYTES      = 24'h080000,
    parameter int unsigned  SECTOR_US      = 50000,
    parameter int unsigned  HALF_BLOCK_US  = 150000,
    parameter int unsigned  BLOCK_US       = 250000,
    parameter int unsigned  CHIP_US        = 2000000,
    // identity values are arbitrary
    parameter logic [7:0]   MAKER_ID       = 8'h5A,
    parameter logic [7:0]   DEVICE_ID      = 8'h12,
    parameter logic [7:0]   MEM_TYPE_ID    = 8'h34,
    parameter logic [7:0]   CAPACITY_ID    = 8'h13,
    parameter logic [127:0] UNIQUE_ID      = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic                  ce,
    // serial link
    input  wire logic                  cs_n,
    input  wire logic                  sclk,
    input  wire logic                  si,
    output logic                       so_out,
    output logic                       so_oe,
    // protection setting
    input  wire logic                  protect_level_bit2,
    input  wire logic                  protect_level_bit1,
    input  wire logic                  protect_level_bit0,
    input  wire logic                  protect_complement,
    // status
    output logic                       write_enable_latch,
    output logic                       write_in_progress,
    // erase request to the array
    output logic                       erase_start,
    output sfe_pkg::sfe_erase_type     erase_kind,
    output logic [23:0]                erase_base,
    output logic                       erase_done
);

    localparam logic [31:0] SECTOR_CYC = 32'(SECTOR_US * sfe_pkg::CLK_PER_US);
    localparam logic [31:0] HALF_CYC   = 32'(HALF_BLOCK_US * sfe_pkg::CLK_PER_US);
    localparam logic [31:0] BLOCK_CYC  = 32'(BLOCK_US * sfe_pkg::CLK_PER_US);
    localparam logic [31:0] CHIP_CYC   = 32'(CHIP_US * sfe_pkg::CLK_PER_US);

    logic [2:0]             pin_lvl;
    logic [2:0]             pin_rise;
    logic [2:0]             pin_fall;
    logic                   cs_low;
    logic                   cs_rise;
    logic                   cs_fall;
    logic                   sclk_rise;
    logic                   sclk_fall;
    logic                   busy;
    logic [2:0]             bp;
    logic [7:0]             status_byte;

    sfe_pkg::sfe_state_type state_reg;
    sfe_pkg::sfe_state_type state_next;
    logic [5:0]             bit_cnt_reg;
    logic [5:0]             bit_cnt_next;
    logic [7:0]             shift_reg;
    logic [7:0]             shift_next;
    logic [7:0]             opcode_reg;
    logic [7:0]             opcode_next;
    logic [23:0]            addr_reg;
    logic [23:0]            addr_next;
    logic [127:0]           out_sr_reg;
    logic [127:0]           out_sr_next;
    logic [2:0]             out_cnt_reg;
    logic [2:0]             out_cnt_next;
    logic                   so_reg;
    logic                   so_next;
    logic                   wel_reg;
    logic                   wel_next;
    logic                   start_reg;
    logic                   start_next;
    sfe_pkg::sfe_erase_type kind_reg;
    sfe_pkg::sfe_erase_type kind_next;
    logic [23:0]            base_reg;
    logic [23:0]            base_next;

    logic [7:0]             rx_byte;
    logic [7:0]             op_now;
    logic [5:0]             cnt_now;
    logic                   is_addr_erase;
    logic                   is_chip;
    logic                   chip_ok;
    logic [23:0]            region_mask;
    logic                   region_prot;
    logic                   start_go;
    logic                   write_enable_cmd_go;
    sfe_pkg::sfe_erase_type kind_dec;
    logic [31:0]            cycles_sel;

    // protected range overlap for an aligned region
    function automatic logic region_protected(input logic [23:0] lo,
                                              input logic [23:0] hi,
                                              input logic [2:0]  lvl,
                                              input logic        cmp);
        logic [31:0] span;
        logic [31:0] edge_addr;
        span = (lvl == 3'h0) ? 32'h0 : ({8'h0, sfe_pkg::BLOCK_BYTES} << (lvl - 3'h1));
        if (span > {8'h0, MEM_BYTES}) begin
            span = {8'h0, MEM_BYTES};
        end
        edge_addr = {8'h0, MEM_BYTES} - span;
        if (!cmp) begin
            return (span != 32'h0) && ({8'h0, hi} >= edge_addr);
        end
        return {8'h0, lo} < edge_addr;
    endfunction : region_protected

    sfe_pin_sync #(
        .W (3)
    ) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ce      (ce),
        .pin_in  ({cs_n, sclk, si}),
        .level   (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    assign cs_low    = ~pin_lvl[2];
    assign cs_rise   = pin_rise[2];
    assign cs_fall   = pin_fall[2];
    assign sclk_rise = pin_rise[1] & cs_low;
    assign sclk_fall = pin_fall[1] & cs_low;

    assign bp          = {protect_level_bit2, protect_level_bit1, protect_level_bit0};
    assign status_byte = {3'h0, bp, wel_reg, busy};
    assign rx_byte     = {shift_reg[6:0], pin_lvl[0]};
    assign op_now      = (bit_cnt_reg == 6'h07) ? rx_byte : opcode_reg;
    assign cnt_now     = (bit_cnt_reg == sfe_pkg::CNT_MAX) ? bit_cnt_reg : bit_cnt_reg + 6'h1;

    always_comb begin
        kind_dec      = sfe_pkg::ERASE_SECTOR;
        region_mask   = ~(sfe_pkg::SECTOR_BYTES - 24'h1);
        is_addr_erase = 1'b0;
        case (opcode_reg)
            sfe_pkg::OP_SECTOR_ERASE: begin
                is_addr_erase = 1'b1;
            end
            sfe_pkg::OP_HALF_BLOCK: begin
                is_addr_erase = 1'b1;
                kind_dec      = sfe_pkg::ERASE_HALF_BLOCK;
                region_mask   = ~(sfe_pkg::HALF_BLOCK_BYTES - 24'h1);
            end
            sfe_pkg::OP_BLOCK_ERASE: begin
                is_addr_erase = 1'b1;
                kind_dec      = sfe_pkg::ERASE_BLOCK;
                region_mask   = ~(sfe_pkg::BLOCK_BYTES - 24'h1);
            end
            default: begin
                kind_dec = sfe_pkg::ERASE_CHIP;
            end
        endcase
    end

    assign is_chip = (opcode_reg == sfe_pkg::OP_CHIP_ERASE_A) ||
                     (opcode_reg == sfe_pkg::OP_CHIP_ERASE_B);
    assign chip_ok = ((bp == 3'h0) && !protect_complement) ||
                     ((bp[2:1] == 2'h3) && protect_complement);
    assign region_prot = region_protected(addr_reg & region_mask,
                                          (addr_reg & region_mask) | ~region_mask,
                                          bp, protect_complement);

    assign start_go = cs_rise && (state_reg == sfe_pkg::ST_SHIFT_IN) && !busy && wel_reg &&
                      ((is_addr_erase && (bit_cnt_reg == sfe_pkg::CNT_ADDR_END) && !region_prot) ||
                       (is_chip && (bit_cnt_reg == sfe_pkg::CNT_OPCODE_END) && chip_ok));
    assign write_enable_cmd_go  = cs_rise && (state_reg == sfe_pkg::ST_SHIFT_IN) && !busy &&
                      (opcode_reg == sfe_pkg::OP_WRITE_ENABLE) &&
                      (bit_cnt_reg == sfe_pkg::CNT_OPCODE_END);

    always_comb begin
        state_next   = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next   = shift_reg;
        opcode_next  = opcode_reg;
        addr_next    = addr_reg;
        out_sr_next  = out_sr_reg;
        out_cnt_next = out_cnt_reg;
        so_next      = so_reg;
        case (state_reg)
            sfe_pkg::ST_IDLE: begin
                if (cs_fall) begin
                    state_next   = sfe_pkg::ST_SHIFT_IN;
                    bit_cnt_next = 6'h0;
                    out_cnt_next = 3'h0;
                end
            end
            sfe_pkg::ST_SHIFT_IN: begin
                if (cs_rise) begin
                    state_next = sfe_pkg::ST_IDLE;
                end else if (sclk_rise) begin
                    shift_next   = rx_byte;
                    bit_cnt_next = cnt_now;
                    if (bit_cnt_reg == 6'h07) begin
                        opcode_next = rx_byte;
                    end
                    if ((bit_cnt_reg >= sfe_pkg::CNT_OPCODE_END) &&
                        (bit_cnt_reg < sfe_pkg::CNT_ADDR_END)) begin
                        addr_next = {addr_reg[22:0], pin_lvl[0]};
                    end
                    if (cnt_now == sfe_pkg::CNT_OPCODE_END) begin
                        if (op_now == sfe_pkg::OP_READ_STATUS) begin
                            state_next  = sfe_pkg::ST_SHIFT_OUT;
                            out_sr_next = {status_byte, 120'h0};
                        end
                        if (op_now == sfe_pkg::OP_IDENT_READ) begin
                            state_next  = busy ? sfe_pkg::ST_IGNORE : sfe_pkg::ST_SHIFT_OUT;
                            out_sr_next = {MAKER_ID, MEM_TYPE_ID, CAPACITY_ID, 104'h0};
                        end
                    end
                    if ((cnt_now == sfe_pkg::CNT_ADDR_END) &&
                        (opcode_reg == sfe_pkg::OP_MAKER_DEVICE_ID)) begin
                        state_next  = sfe_pkg::ST_SHIFT_OUT;
                        out_sr_next = {MAKER_ID, DEVICE_ID, 112'h0};
                    end
                    if ((cnt_now == sfe_pkg::CNT_DUMMY_END) &&
                        (opcode_reg == sfe_pkg::OP_UNIQUE_ID)) begin
                        state_next  = sfe_pkg::ST_SHIFT_OUT;
                        out_sr_next = UNIQUE_ID;
                    end
                end
            end
            sfe_pkg::ST_SHIFT_OUT: begin
                if (cs_rise) begin
                    state_next = sfe_pkg::ST_IDLE;
                end else if (sclk_fall) begin
                    so_next      = out_sr_reg[127];
                    out_sr_next  = {out_sr_reg[126:0], 1'b0};
                    out_cnt_next = out_cnt_reg + 3'h1;
                    if ((opcode_reg == sfe_pkg::OP_READ_STATUS) && (out_cnt_reg == 3'h7)) begin
                        out_sr_next = {status_byte, 120'h0};
                    end
                end
            end
            sfe_pkg::ST_IGNORE: begin
                if (cs_rise) begin
                    state_next = sfe_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = sfe_pkg::ST_IDLE;
            end
        endcase
    end

    always_comb begin
        wel_next   = wel_reg;
        start_next = start_go;
        kind_next  = kind_reg;
        base_next  = base_reg;
        if (start_go) begin
            wel_next  = 1'b0;
            kind_next = kind_dec;
            base_next = is_chip ? 24'h0 : (addr_reg & region_mask);
        end else if (write_enable_cmd_go) begin
            wel_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg   <= sfe_pkg::ST_IDLE;
            bit_cnt_reg <= 6'h0;
            shift_reg   <= 8'h0;
            opcode_reg  <= 8'h0;
            addr_reg    <= 24'h0;
            out_sr_reg  <= 128'h0;
            out_cnt_reg <= 3'h0;
            so_reg      <= 1'b0;
            wel_reg     <= 1'b0;
            start_reg   <= 1'b0;
            kind_reg    <= sfe_pkg::ERASE_SECTOR;
            base_reg    <= 24'h0;
        end else if (ce) begin
            state_reg   <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg   <= shift_next;
            opcode_reg  <= opcode_next;
            addr_reg    <= addr_next;
            out_sr_reg  <= out_sr_next;
            out_cnt_reg <= out_cnt_next;
            so_reg      <= so_next;
            wel_reg     <= wel_next;
            start_reg   <= start_next;
            kind_reg    <= kind_next;
            base_reg    <= base_next;
        end
    end

    always_comb begin
        case (kind_reg)
            sfe_pkg::ERASE_SECTOR:     cycles_sel = SECTOR_CYC;
            sfe_pkg::ERASE_HALF_BLOCK: cycles_sel = HALF_CYC;
            sfe_pkg::ERASE_BLOCK:      cycles_sel = BLOCK_CYC;
            default:                   cycles_sel = CHIP_CYC;
        endcase
    end

    sfe_erase_timer u_timer (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ce      (ce),
        .start   (start_reg),
        .cycles  (cycles_sel),
        .busy    (busy),
        .done    (erase_done)
    );

    assign so_out             = so_reg;
    assign so_oe              = (state_reg == sfe_pkg::ST_SHIFT_OUT) && cs_low;
    assign write_enable_latch = wel_reg;
    assign write_in_progress  = busy;
    assign erase_start        = start_reg;
    assign erase_kind         = kind_reg;
    assign erase_base         = base_reg;

    property p_wip_after_start;
        @(posedge clk_sys) disable iff (reset || !ce)
        start_reg |=> write_in_progress;
    endproperty
    a_wip_after_start: assert property (p_wip_after_start) else $error("no busy after start");

    property p_start_needs_wel;
        @(posedge clk_sys) disable iff (reset || !ce)
        start_go |-> wel_reg ##1 (start_reg && !wel_reg);
    endproperty
    a_start_needs_wel: assert property (p_start_needs_wel) else $error("latch misuse at start");

    property p_no_start_busy;
        @(posedge clk_sys) disable iff (reset || !ce)
        write_in_progress |-> !erase_start;
    endproperty
    a_no_start_busy: assert property (p_no_start_busy) else $error("erase while busy");

    property p_exact_addr_len;
        @(posedge clk_sys) disable iff (reset || !ce)
        (start_go && is_addr_erase) |-> (bit_cnt_reg == 6'h20) && !region_prot;
    endproperty
    a_exact_addr_len: assert property (p_exact_addr_len) else $error("bad erase length");

    property p_chip_protect;
        @(posedge clk_sys) disable iff (reset || !ce)
        (start_go && is_chip) |-> ((bp == 3'h0) && !protect_complement) ||
                                  ((bp[2:1] == 2'h3) && protect_complement);
    endproperty
    a_chip_protect: assert property (p_chip_protect) else $error("chip erase protected");

    property p_ident_busy;
        @(posedge clk_sys) disable iff (reset || !ce)
        (so_oe && (opcode_reg == sfe_pkg::OP_IDENT_READ)) |-> $past(state_reg) != sfe_pkg::ST_IGNORE;
    endproperty
    a_ident_busy: assert property (p_ident_busy) else $error("id read while busy");

    property p_cs_rise_idle;
        @(posedge clk_sys) disable iff (reset || !ce)
        cs_rise |=> (state_reg == sfe_pkg::ST_IDLE) && !so_oe;
    endproperty
    a_cs_rise_idle: assert property (p_cs_rise_idle) else $error("output not ended");

    property p_sample_rise;
        @(posedge clk_sys) disable iff (reset || !ce)
        (state_reg == sfe_pkg::ST_SHIFT_IN && sclk_rise && !cs_rise && bit_cnt_reg < 6'h3F)
            |=> bit_cnt_reg == $past(bit_cnt_reg) + 6'h1;
    endproperty
    a_sample_rise: assert property (p_sample_rise) else $error("bit not counted");

endmodule : sfe_cmd

//--- sfe_host.sv
// Purpose: host controller model for the serial link
// Assumes: mode 0, sclk period 8 clk_sys, sclk low between frames
// Notes:   rx takes so_out at each sclk rise
module sfe_host (
    // clock
    input  wire logic clk_sys,
    // serial link
    input  wire logic so_out,
    output logic      cs_n,
    output logic      sclk,
    output logic      si
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end
    task automatic xfer(input logic [167:0] tx, input int n, output logic [167:0] rx);
        rx = '0;
        @(posedge clk_sys);
        cs_n <= 1'b0;
        // select held, si moves while sclk low
        for (int i = n - 1; i >= 0; i--) begin
            si <= tx[i];
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b1;
            rx = {rx[166:0], so_out};
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b0;
        end
        repeat (2) @(posedge clk_sys);
        cs_n <= 1'b1;
        si   <= ~si;
        repeat (8) @(posedge clk_sys);
    endtask : xfer
endmodule : sfe_host

//--- testbench.sv
// Purpose: self-checking bench for erase and id commands
// Assumes: short erase durations, ce dropped once during a cycle
// Notes:   monitor counts erase pulses and wip length
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, reset = 1'b1, ce = 1'b1, cs_n, sclk, si, so_out, so_oe, erase_start;
    logic write_enable_latch, write_in_progress, protect_complement = 1'b0;
    logic [2:0] bp = 3'h0;
    sfe_pkg::sfe_erase_type erase_kind;
    logic [23:0] erase_base, base_l;
    logic [1:0] kind_l;
    logic erase_done;
    logic [167:0] rx;
    int errors = 0, cmp_count = 0, starts = 0, wip_cnt = 0, cyc = 0, oe_cnt = 0, dones = 0;
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // released line shows the inverse of its last value
    wire so_line = so_oe ? so_out : ~so_out;
    sfe_host host (.clk_sys, .so_out(so_line), .cs_n, .sclk, .si);
    sfe_cmd #(.SECTOR_US(40), .HALF_BLOCK_US(41), .BLOCK_US(42), .CHIP_US(43))
        dut (.clk_sys, .reset, .ce, .cs_n, .sclk,
        .si, .so_out, .so_oe, .protect_level_bit2(bp[2]), .protect_level_bit1(bp[1]),
        .protect_level_bit0(bp[0]), .protect_complement, .write_enable_latch,
        .write_in_progress, .erase_start, .erase_kind, .erase_base, .erase_done);
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (erase_start === 1'b1) begin
            starts  <= starts + 1;
            kind_l  <= erase_kind;
            base_l  <= erase_base;
            wip_cnt <= 0;
        end else if (write_in_progress === 1'b1) begin
            wip_cnt <= wip_cnt + 1;
        end
        if (so_oe === 1'b1) oe_cnt <= oe_cnt + 1;
        if (erase_done === 1'b1) dones <= dones + 1;
        if (cyc == 40000) begin
            errors++;
            tally_and_finish;
        end
    end
    task automatic chk(input bit c, input string m);
        cmp_count++;
        if (!c) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic erase(bit w, logic [31:0] tx, int n, bit ok, logic [1:0] k,
                         logic [23:0] b, int us, int fz = 0);
        int s0, o0, d0;
        if (w) host.xfer(168'h06, 8, rx);
        s0 = starts;
        d0 = dones;
        host.xfer(168'(tx), n, rx);
        repeat (10) @(posedge clk_sys);
        chk(starts == s0 + int'(ok), "accept");
        if (!ok) begin
            chk(write_enable_latch === w && write_in_progress === 1'b0, "refused");
            return;
        end
        chk(kind_l === k && base_l === b && write_enable_latch === 1'b0, "start");
        host.xfer(168'h0500, 16, rx);
        chk(rx[1:0] === 2'b01, "status");
        // clock enable low freezes the cycle
        if (fz > 0) begin
            ce <= 1'b0;
            repeat (fz) @(posedge clk_sys);
            ce <= 1'b1;
        end
        o0 = oe_cnt;
        host.xfer(168'h9F000000, 32, rx);
        chk(oe_cnt == o0, "id in cycle");
        host.xfer(168'h06, 8, rx);
        host.xfer(168'h20000000, 32, rx);
        chk(starts == s0 + 1 && write_enable_latch === 1'b0, "erase in cycle");
        for (int i = 0; i < 2000 && write_in_progress !== 1'b0; i++) @(posedge clk_sys);
        @(posedge clk_sys);
        chk(wip_cnt == us * 20 + fz, "length");
        chk(dones == d0 + 1, "done pulse");
    endtask : erase
    task automatic tally_and_finish;
        if (errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        erase(1, 32'h20012345, 32, 1, 2'h0, 24'h012000, 40);
        erase(0, 32'h20012345, 32, 0, 2'h0, 24'h0, 0);
        erase(1, 32'h100091A2, 31, 0, 2'h0, 24'h0, 0);
        erase(1, 32'h5201ABCD, 32, 1, 2'h1, 24'h018000, 41);
        erase(1, 32'hD801ABCD, 32, 1, 2'h2, 24'h010000, 42);
        erase(1, 32'h60, 8, 1, 2'h3, 24'h0, 43, 7);
        bp <= 3'h1;
        erase(1, 32'h2007F123, 32, 0, 2'h0, 24'h0, 0);
        erase(1, 32'hC7, 8, 0, 2'h0, 24'h0, 0);
        bp <= 3'h6;
        protect_complement <= 1'b1;
        erase(1, 32'hC7, 8, 1, 2'h3, 24'h0, 43);
        host.xfer(168'h9F000000, 32, rx);
        chk(rx[23:0] === 24'h5A3413, "ident");
        host.xfer(168'h9F000, 20, rx);
        chk(rx[11:0] === 12'h5A3 && so_oe === 1'b0, "ident cut");
        host.xfer(168'h900000000000, 48, rx);
        chk(rx[15:0] === 16'h5A12, "maker device");
        host.xfer(168'h4B00000000 << 128, 168, rx);
        chk(rx[127:0] === 128'h0123456789ABCDEF0F1E2D3C4B5A6978, "unique");
        tally_and_finish;
    end
endmodule : testbench
